// ==== core/usr_pkg.sv ====
// package: register map, field positions, types for the serial port
package usr_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_IRQ_FLAGS = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN    = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_IRQ_PRIO  = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_RX_CTRL   = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_RX_DATA   = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_TX_CTRL   = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_BAUD_DIV  = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_TX_DATA   = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_GLOBAL    = 4'h8;
  // irq flag / enable / priority positions
  localparam int BIT_RX_IRQ = 5;
  localparam int BIT_TX_IRQ = 4;
  // receive control/status positions
  localparam int BIT_PORT_EN = 7;
  localparam int BIT_RX9     = 6;
  localparam int BIT_SRX_EN  = 5;
  localparam int BIT_CRX_EN  = 4;
  localparam int BIT_ADDR_EN = 3;
  localparam int BIT_FRAME   = 2;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_RX9TH   = 0;
  // transmit control/status positions
  localparam int BIT_MASTER  = 7;
  localparam int BIT_TX9     = 6;
  localparam int BIT_TX_EN   = 5;
  localparam int BIT_SYNC    = 4;
  localparam int BIT_HISPEED = 2;
  localparam int BIT_SH_EMPTY = 1;
  localparam int BIT_TX9TH   = 0;
  localparam int BIT_GIE     = 0;
  localparam logic [DATA_W-1:0] RST_REG     = 8'h00;
  localparam logic [DATA_W-1:0] RST_TX_CTRL = 8'h02;
  // sampling and baud constants
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_MID  = 4'h7;
  localparam logic [3:0] SAMPLE_LAST = 4'hf;
  localparam logic [1:0] LOW_SPEED_PRE = 2'h3;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE  = 4'h9;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } usr_bus_req_t;

  typedef struct packed {
    logic ckOut;
    logic ckOe;
    logic dtOut;
    logic dtOe;
  } usr_pin_out_t;

  typedef struct packed {
    logic rxReq;
    logic rxHigh;
    logic txReq;
    logic txHigh;
  } usr_irq_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usr_rx_state_t;
endpackage

// ==== core/usr_serial_port.sv ====
// module: async receiver and sync master transmitter with register port
`timescale 1ns/100ps
module usr_serial_port
  import usr_pkg::*;
(
  // clock, reset, enable
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  ce,
  // register port
  input  wire usr_pkg::usr_bus_req_t busReq,
  output      logic [7:0]            rdData,
  // pins
  input  wire logic                  dataPinIn,
  input  wire logic                  clockPinIn,
  output      usr_pkg::usr_pin_out_t pinOut,
  // interrupt requests
  output      usr_pkg::usr_irq_t     irq
);
  import usr_pkg::*;

  logic [7:0] irqEn, irqPrio, rxCtrl, txCtrl, baudDiv, txBuf, rxBuf;
  logic global_irq_enable, rxFlag, txFlag, bufFull, frameErr, overrunErr, rxNinth;
  logic [1:0] rxSync;
  logic rxLine;
  logic [7:0] brgCnt;
  logic [1:0] preCnt;
  logic brgTick, sampleTick;
  usr_rx_state_t rxState;
  logic [3:0] sc, rxBitCnt;
  logic [8:0] rsr;
  logic rxDone, rxDiscard, rdRx, wrTx, stopBit;
  logic [7:0] rxWord;
  logic rxWord9;
  logic [8:0] transmit_shifter;
  logic [3:0] txCnt;
  logic ckLevel, tsrEmpty, txLoad, rxInhibit;

  wire portEn   = rxCtrl[BIT_PORT_EN];
  wire rx9      = rxCtrl[BIT_RX9];
  wire crxEn    = rxCtrl[BIT_CRX_EN];
  wire srxEn    = rxCtrl[BIT_SRX_EN];
  wire addrEn   = rxCtrl[BIT_ADDR_EN];
  wire syncMode = txCtrl[BIT_SYNC];
  wire master   = txCtrl[BIT_MASTER];
  wire transmit_enable     = txCtrl[BIT_TX_EN];
  wire tx9      = txCtrl[BIT_TX9];
  wire syncMaster = portEn && syncMode && master;
  wire asyncRx  = portEn && !syncMode && crxEn;

  function automatic logic hit(input logic [ADDR_W-1:0] off, input logic strobe);
    hit = strobe && (busReq.addr == off);
  endfunction

  assign rdRx = hit(OFF_RX_DATA, busReq.rd);
  assign wrTx = hit(OFF_TX_DATA, busReq.wr);

  // pin synchroniser, first stage read only by second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxSync <= 2'h3;
    end else if (ce) begin
      rxSync <= {rxSync[0], dataPinIn};
    end
  end
  assign rxLine = rxSync[1];

  // software-written control registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqEn   <= RST_REG;
      irqPrio <= RST_REG;
      rxCtrl  <= RST_REG;
      txCtrl  <= RST_TX_CTRL;
      baudDiv <= RST_REG;
      global_irq_enable     <= 1'b0;
    end else if (ce && busReq.wr) begin
      unique case (busReq.addr)
        OFF_IRQ_EN: begin
          irqEn <= busReq.wdata & (8'h30);
        end
        OFF_IRQ_PRIO: begin
          irqPrio <= busReq.wdata & (8'h30);
        end
        OFF_RX_CTRL: begin
          rxCtrl <= busReq.wdata & (8'hf8);
        end
        OFF_TX_CTRL: begin
          txCtrl <= busReq.wdata & (8'hf5);
        end
        OFF_BAUD_DIV: begin
          baudDiv <= busReq.wdata;
        end
        OFF_GLOBAL: begin
          global_irq_enable <= busReq.wdata[BIT_GIE];
        end
        default: begin
        end
      endcase
    end
  end

  // baud tick every divisor+1 clocks; a lowered divisor never waits for wrap
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      brgCnt <= 8'h00;
      preCnt <= 2'h0;
    end else if (ce) begin
      if (brgTick) begin
        brgCnt <= 8'h00;
        preCnt <= preCnt + 2'h1;
      end else begin
        brgCnt <= brgCnt + 8'h01;
      end
    end
  end
  assign brgTick = (brgCnt >= baudDiv);
  // fast: x16 tick used directly; slow: x64 tick divided by four
  assign sampleTick = brgTick && (txCtrl[BIT_HISPEED] || preCnt == LOW_SPEED_PRE);

  // async receive recovery, sixteen samples per bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxState  <= RX_IDLE;
      sc       <= 4'h0;
      rxBitCnt <= 4'h0;
      rsr      <= 9'h000;
    end else if (ce) begin
      if (!asyncRx) begin
        rxState <= RX_IDLE;
        sc      <= 4'h0;
      end else if (sampleTick) begin
        sc <= sc + 4'h1;
        unique case (rxState)
          RX_IDLE: begin
            sc <= 4'h0;
            if (!rxLine) begin
              rxState <= RX_START;
            end
          end
          RX_START: begin
            if (sc == SAMPLE_MID) begin
              sc       <= 4'h0;
              rxBitCnt <= 4'h0;
              rxState  <= rxLine ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (sc == SAMPLE_LAST) begin
              rsr      <= {rxLine, rsr[8:1]};
              rxBitCnt <= rxBitCnt + 4'h1;
              if (rxBitCnt + 4'h1 == (rx9 ? BITS_NINE : BITS_EIGHT)) begin
                rxState <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (sc == SAMPLE_LAST) begin
              rxState <= RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign stopBit = rxLine;
  assign rxDone  = asyncRx && sampleTick && rxState == RX_STOP && sc == SAMPLE_LAST;
  assign rxWord  = rx9 ? rsr[7:0] : rsr[8:1];
  assign rxWord9 = rx9 && rsr[8];
  assign rxDiscard = addrEn && rx9 && !rxWord9;

  // receive buffer, flag and errors
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxBuf      <= RST_REG;
      rxNinth    <= 1'b0;
      frameErr   <= 1'b0;
      overrunErr <= 1'b0;
      rxFlag     <= 1'b0;
    end else if (ce) begin
      if (rdRx) begin
        rxFlag <= 1'b0;
      end
      if (!crxEn) begin
        frameErr   <= 1'b0;
        overrunErr <= 1'b0;
      end else if (rxDone && !rxDiscard && !overrunErr) begin
        if (rxFlag && !rdRx) begin
          overrunErr <= 1'b1;
        end else begin
          rxBuf    <= rxWord;
          rxNinth  <= rxWord9;
          frameErr <= !stopBit;
          rxFlag   <= 1'b1;
        end
      end
    end
  end

  // transmit buffer and empty flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txBuf   <= RST_REG;
      bufFull <= 1'b0;
      txFlag  <= 1'b0;
    end else if (ce) begin
      if (wrTx) begin
        txBuf   <= busReq.wdata;
        bufFull <= 1'b1;
      end else if (txLoad) begin
        bufFull <= 1'b0;
      end
      txFlag <= transmit_enable && !bufFull;
    end
  end

  assign tsrEmpty  = (txCnt == 4'h0);
  assign txLoad    = bufFull && tsrEmpty && transmit_enable && !wrTx;
  assign rxInhibit = syncMode && (crxEn || srxEn);

  // sync master shifter, data changes while clock low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      transmit_shifter     <= 9'h1ff;
      txCnt   <= 4'h0;
      ckLevel <= 1'b0;
    end else if (ce) begin
      if (!transmit_enable) begin
        txCnt   <= 4'h0;
        ckLevel <= 1'b0;
      end else if (txLoad) begin
        transmit_shifter   <= {txCtrl[BIT_TX9TH], txBuf};
        txCnt <= tx9 ? BITS_NINE : BITS_EIGHT;
      end else if (syncMaster && !rxInhibit && !tsrEmpty && brgTick) begin
        ckLevel <= !ckLevel;
        if (ckLevel) begin
          transmit_shifter   <= {1'b1, transmit_shifter[8:1]};
          txCnt <= txCnt - 4'h1;
        end
      end
    end
  end

  // pins: in sync mode clock and data lines
  always_comb begin
    pinOut.ckOut = syncMode ? ckLevel : 1'b1;
    pinOut.ckOe  = portEn && (!syncMode || master);
    pinOut.dtOut = transmit_shifter[0];
    pinOut.dtOe  = syncMaster && !rxInhibit && !tsrEmpty;
  end

  always_comb begin
    irq.rxReq  = rxFlag && irqEn[BIT_RX_IRQ] && global_irq_enable;
    irq.rxHigh = irq.rxReq && irqPrio[BIT_RX_IRQ];
    irq.txReq  = txFlag && irqEn[BIT_TX_IRQ] && global_irq_enable;
    irq.txHigh = irq.txReq && irqPrio[BIT_TX_IRQ];
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdData <= 8'h00;
    end else if (ce) begin
      rdData <= 8'h00;
      if (busReq.rd) begin
        unique case (busReq.addr)
          OFF_IRQ_FLAGS: begin
            rdData <= {2'h0, rxFlag, txFlag, 4'h0};
          end
          OFF_IRQ_EN: begin
            rdData <= irqEn;
          end
          OFF_IRQ_PRIO: begin
            rdData <= irqPrio;
          end
          OFF_RX_CTRL: begin
            rdData <= {rxCtrl[7:3], frameErr, overrunErr, rxNinth};
          end
          OFF_RX_DATA: begin
            rdData <= rxBuf;
          end
          OFF_TX_CTRL: begin
            rdData <= {txCtrl[7:2], tsrEmpty, txCtrl[0]};
          end
          OFF_BAUD_DIV: begin
            rdData <= baudDiv;
          end
          OFF_TX_DATA: begin
            rdData <= txBuf;
          end
          OFF_GLOBAL: begin
            rdData <= {7'h00, global_irq_enable};
          end
          default: begin
          end
        endcase
      end
    end
  end

  // checks; disabled during reset and while enable low
  sequence s_tx_load;
    txLoad ##1 !tsrEmpty;
  endsequence

  property p_start_mid;
    @(posedge clk) disable iff (sys_rst || !ce)
      asyncRx && sampleTick && rxState == RX_START && sc == SAMPLE_MID && !rxLine
      |=> rxState == RX_DATA && sc == 4'h0;
  endproperty
  a_start_mid: assert property (p_start_mid) else $error("start not confirmed mid-bit");

  property p_continuous_rx_enable_off;
    @(posedge clk) disable iff (sys_rst || !ce)
      !crxEn |=> !frameErr && !overrunErr && rxState == RX_IDLE;
  endproperty
  a_continuous_rx_enable_off: assert property (p_continuous_rx_enable_off) else $error("errors survive receive disable");

  property p_rx_flag;
    @(posedge clk) disable iff (sys_rst || !ce)
      rxDone && crxEn && !rxDiscard && !overrunErr && !rxFlag |=> rxFlag && rxBuf == $past(rxWord);
  endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("word not delivered");

  property p_addr_drop;
    @(posedge clk) disable iff (sys_rst || !ce)
      rxDone && rxDiscard && !rxFlag |=> !rxFlag;
  endproperty
  a_addr_drop: assert property (p_addr_drop) else $error("address word not discarded");

  property p_overrun;
    @(posedge clk) disable iff (sys_rst || !ce)
      rxDone && crxEn && rxFlag && !rdRx && !rxDiscard |=> overrunErr;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");

  property p_tx_flag_delay;
    @(posedge clk) disable iff (sys_rst || !ce)
      wrTx |-> ##2 !txFlag;
  endproperty
  a_tx_flag_delay: assert property (p_tx_flag_delay) else $error("flag not cleared");

  property p_load_flag;
    @(posedge clk) disable iff (sys_rst || !ce)
      s_tx_load ##0 transmit_enable ##1 transmit_enable |-> txFlag || bufFull;
  endproperty
  a_load_flag: assert property (p_load_flag) else $error("transfer did not set flag");

  property p_half_duplex;
    @(posedge clk) disable iff (sys_rst || !ce)
      rxInhibit && transmit_enable && !txLoad |-> !pinOut.dtOe ##1 $stable(txCnt);
  endproperty
  a_half_duplex: assert property (p_half_duplex) else $error("transmit during receive");

  property p_no_reload;
    @(posedge clk) disable iff (sys_rst || !ce)
      !tsrEmpty && transmit_enable && !(ckLevel && brgTick && syncMaster && !rxInhibit) |=> $stable(transmit_shifter);
  endproperty
  a_no_reload: assert property (p_no_reload) else $error("shifter reloaded early");

  property p_ck_master;
    @(posedge clk) disable iff (sys_rst || !ce)
      syncMode && !master |-> !pinOut.ckOe && !pinOut.dtOe;
  endproperty
  a_ck_master: assert property (p_ck_master) else $error("slave drives clock");
endmodule // usr_serial_port

// ==== dv/test_usr_serial_port.sv ====
// testbench: register-level tests of the serial port against a remote node
`timescale 1ns/100ps
module test_usr_serial_port;
  import usr_pkg::*;
  logic         clk = 1'b0;
  logic         sysRst = 1'b1;
  logic         sClr = 1'b0;
  logic         ce = 1'b1;
  logic         dataPin;
  usr_bus_req_t busReq = '0;
  logic [7:0]   rdData;
  usr_pin_out_t pinOut;
  usr_irq_t     irq;
  logic [31:0]  sBits;
  logic [5:0]   sCount;
  logic [7:0]   d;
  int           num_errors = 0;
  int           n_tests = 0;

  always #10 clk = ~clk;

  usr_serial_port DUT (.clk(clk), .sys_rst(sysRst), .ce(ce), .busReq(busReq),
    .rdData(rdData), .dataPinIn(dataPin), .clockPinIn(1'b1), .pinOut(pinOut), .irq(irq));
  usr_remote_node PARTNER (.clk(clk), .sClr(sClr), .pinOut(pinOut), .dataPin(dataPin),
    .sBits(sBits), .sCount(sCount));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    busReq <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    busReq <= '0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    busReq <= '0;
    #1 v = rdData;
    @(posedge clk);
  endtask

  task automatic chkr(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  // bounded wait for bits in a register
  task automatic poll(input logic [3:0] a, input logic [7:0] m);
    logic [7:0] v;
    for (int i = 0; i < 400; i++) begin
      rd(a, v);
      if ((v & m) === m) return;
    end
    num_errors++;
    $display("mismatch at %0t: wait timed out", $time);
    end_sim();
  endtask

  task automatic clr();
    sClr <= 1'b1;
    @(posedge clk);
    sClr <= 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      chkr(4'(i), (i == 5) ? RST_TX_CTRL : RST_REG);
    end
    chk(pinOut.ckOe, 1'b0);
    wr(4'hc, 8'hff);
    chkr(4'hc, 8'h00);
    wr(OFF_BAUD_DIV, 8'h5a);
    chkr(OFF_BAUD_DIV, 8'h5a);
    // write ignored while enable low
    ce <= 1'b0;
    wr(OFF_BAUD_DIV, 8'h00);
    ce <= 1'b1;
    chkr(OFF_BAUD_DIV, 8'h5a);
    wr(OFF_BAUD_DIV, 8'h00);
    $display("test reset done");
    // slow derivation: 64 clocks per bit
    wr(OFF_RX_CTRL, 8'h90);
    wr(OFF_IRQ_EN, 8'h20);
    wr(OFF_IRQ_PRIO, 8'h20);
    wr(OFF_GLOBAL, 8'h01);
    chk(pinOut.ckOe, 1'b1);
    PARTNER.send(9'h0a5, 8, 1'b1, 64);
    poll(OFF_IRQ_FLAGS, 8'h20);
    chk(irq.rxReq, 1'b1);
    chk(irq.rxHigh, 1'b1);
    chkr(OFF_RX_CTRL, 8'h90);
    chkr(OFF_RX_DATA, 8'ha5);
    chk(irq.rxReq, 1'b0);
    $display("test async receive done");
    // fast derivation: 16 clocks per bit, global enable off
    wr(OFF_TX_CTRL, 8'h04);
    wr(OFF_GLOBAL, 8'h00);
    PARTNER.send(9'h03c, 8, 1'b1, 16);
    PARTNER.send(9'h0c4, 8, 1'b1, 16);
    chkr(OFF_RX_CTRL, 8'h92);
    chk(irq.rxReq, 1'b0);
    chkr(OFF_RX_DATA, 8'h3c);
    wr(OFF_RX_CTRL, 8'h80);
    chkr(OFF_RX_CTRL, 8'h80);
    wr(OFF_RX_CTRL, 8'h90);
    PARTNER.send(9'h066, 8, 1'b0, 16);
    poll(OFF_IRQ_FLAGS, 8'h20);
    chkr(OFF_RX_CTRL, 8'h94);
    wr(OFF_RX_CTRL, 8'h80);
    chkr(OFF_RX_CTRL, 8'h80);
    chkr(OFF_RX_DATA, 8'h66);
    PARTNER.send(9'h055, 8, 1'b1, 16);
    rd(OFF_IRQ_FLAGS, d);
    chk(d[5], 1'b0);
    $display("test errors done");
    wr(OFF_RX_CTRL, 8'hd8);
    PARTNER.send(9'h011, 9, 1'b1, 16);
    rd(OFF_IRQ_FLAGS, d);
    chk(d[5], 1'b0);
    PARTNER.send(9'h133, 9, 1'b1, 16);
    poll(OFF_IRQ_FLAGS, 8'h20);
    chkr(OFF_RX_CTRL, 8'hd9);
    chkr(OFF_RX_DATA, 8'h33);
    wr(OFF_RX_CTRL, 8'hd0);
    PARTNER.send(9'h044, 9, 1'b1, 16);
    poll(OFF_IRQ_FLAGS, 8'h20);
    chkr(OFF_RX_CTRL, 8'hd0);
    chkr(OFF_RX_DATA, 8'h44);
    $display("test address detect done");
    // sync master transmit
    wr(OFF_RX_CTRL, 8'h80);
    wr(OFF_TX_CTRL, 8'h30);
    chk(pinOut.ckOe, 1'b0);
    wr(OFF_TX_CTRL, 8'hb0);
    chk(pinOut.ckOe, 1'b1);
    chkr(OFF_IRQ_FLAGS, 8'h10);
    clr();
    wr(OFF_TX_DATA, 8'h5a);
    wr(OFF_TX_DATA, 8'hc3);
    chk(pinOut.dtOe, 1'b1);
    chkr(OFF_IRQ_FLAGS, 8'h00);
    wr(OFF_IRQ_FLAGS, 8'h10);
    chkr(OFF_IRQ_FLAGS, 8'h00);
    chkr(OFF_TX_CTRL, 8'hb0);
    poll(OFF_IRQ_FLAGS, 8'h10);
    poll(OFF_TX_CTRL, 8'h02);
    chk(sCount, 6'd16);
    chk(sBits[31:16], 16'hc35a);
    // receive enable holds the shifter
    wr(OFF_RX_CTRL, 8'ha0);
    clr();
    wr(OFF_TX_DATA, 8'h77);
    repeat (100) @(posedge clk);
    chk(sCount, 6'd0);
    chk(pinOut.dtOe, 1'b0);
    wr(OFF_RX_CTRL, 8'h80);
    repeat (4) @(posedge clk);
    poll(OFF_TX_CTRL, 8'h02);
    chk(sBits[31:24], 8'h77);
    $display("test sync transmit done");
    wr(OFF_TX_CTRL, 8'hf1);
    wr(OFF_IRQ_EN, 8'h10);
    wr(OFF_GLOBAL, 8'h01);
    chk(irq.txReq, 1'b1);
    chk(irq.txHigh, 1'b0);
    wr(OFF_IRQ_PRIO, 8'h30);
    chk(irq.txHigh, 1'b1);
    clr();
    busReq <= '{OFF_TX_DATA, 8'h81, 1'b1, 1'b0};
    @(posedge clk);
    busReq <= '0;
    #1 chk(irq.txReq, 1'b1);
    @(posedge clk);
    #1 chk(irq.txReq, 1'b0);
    @(posedge clk);
    #1 chk(irq.txReq, 1'b1);
    @(posedge clk);
    repeat (4) @(posedge clk);
    poll(OFF_TX_CTRL, 8'h02);
    chk(sCount, 6'd9);
    chk(sBits[31:23], 9'h181);
    wr(OFF_IRQ_EN, 8'h00);
    chk(irq.txReq, 1'b0);
    $display("test nine bit transmit done");
    end_sim();
  end
endmodule // test_usr_serial_port

// ==== dv/usr_remote_node.sv ====
// remote serial node: async frame sender and sync data collector
`timescale 1ns/100ps
module usr_remote_node
  import usr_pkg::*;
(
  // clock and control
  input  wire logic                  clk,
  input  wire logic                  sClr,
  // pins
  input  wire usr_pkg::usr_pin_out_t pinOut,
  output      logic                  dataPin,
  // collected sync bits
  output      logic [31:0]           sBits,
  output      logic [5:0]            sCount
);
  import usr_pkg::*;
  logic ckPrev;

  initial begin
    dataPin = 1'b1;
    ckPrev  = 1'b1;
    sBits   = '0;
    sCount  = '0;
  end

  // start, data lsb first, stop, two idle bits
  task automatic send(input logic [8:0] w, input int n, input logic stopLvl, input int bt);
    for (int i = -1; i < n + 3; i++) begin
      dataPin <= (i < 0) ? 1'b0 : (i < n) ? w[i] : (i == n) ? stopLvl : 1'b1;
      repeat (bt) @(posedge clk);
    end
  endtask

  // data taken on rising shift clock while driven
  always @(posedge clk) begin
    ckPrev <= pinOut.ckOut;
    if (sClr) begin
      sCount <= '0;
    end else if (pinOut.ckOut && !ckPrev && pinOut.dtOe) begin
      sBits  <= {pinOut.dtOut, sBits[31:1]};
      sCount <= sCount + 6'h01;
    end
  end
endmodule // usr_remote_node
